// >>> verilog/frc_defines.svh
// Constants for the reset, mode and retransmit control of the buffered data path.
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

`define FRC_DATA_WIDTH      36
`define FRC_FIFO_DEPTH      16
`define FRC_AE_OFFSET       2
`define FRC_AF_OFFSET       2
`define FRC_PAE_RST         1'b0
`define FRC_PAF_RST         1'b1
`define FRC_HF_RST          1'b1
`define FRC_EF_RST          1'b0
`define FRC_FF_RST          1'b1
`define FRC_OR_RST          1'b1
`define FRC_IR_RST          1'b0
`define FRC_DATA_RST        36'h0_0000_0000
`define FRC_MODE_STD        1'b0
`define FRC_ASYNC_SEL_RST   1'b1
`define FRC_RTLAT_NORMAL    1'b0
`define FRC_CFG_RST         1'b0

`endif

// >>> verilog/frc_pkg.sv
// Types shared by the reset, mode and retransmit control of the buffered data path.
package frc_pkg;

   typedef enum logic {
      RT_IDLE,
      RT_SETUP
   } frc_rt_state_t;

endpackage

// >>> verilog/frc_ctrl.sv
// Storage buffer and reset, mode and retransmit control of the dual port data buffer.
//
// Behaviour
// - Master reset clears pointers, sets level flags.
// - Mode pin low: standard mode, empty/full flags.
// - Mode pin high: fall-through mode, ready flags.
// - Configuration pins captured during master reset.
// - Master reset zeroes the output register.
// - Partial reset clears pointers, sets level flags.
// - Partial reset keeps mode, sets its flags.
// - Partial reset keeps settings, zeroes output register.
// - Async write: write clock edge stores data.
// - Async write: full flag follows every operation.
// - Async read: read clock edge moves word out.
// - Output enable gates data bus without clock.
// - Async read: empty flag follows every operation.
// - Replay request on read edge rewinds pointer.
// - Standard: empty low during setup, reads need enable.
// - Fall-through: ready high in setup, first word shown.
// - Replay latency chosen at master reset.
// - Zero latency loads first word on request edge.
// - Almost flags after replay follow their clock edges; half full follows the level at once.
`timescale 1ns/100ps
`include "frc_defines.svh"

module frc_fifo #(
   parameter int WIDTH = `FRC_DATA_WIDTH,
   parameter int DEPTH = `FRC_FIFO_DEPTH,
   parameter int LW    = $clog2(DEPTH) + 1
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i,
   output logic      [WIDTH-1:0] rd_data_o,
   input  wire logic             rewind_i,
   input  wire logic             rewind_pop_i,
   output logic      [WIDTH-1:0] first_data_o,
   output logic      [LW-1:0]    level_o
);
   import frc_pkg::*;

   localparam int AW = LW - 1;
   localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
   localparam logic [LW-1:0] ONE_PTR    = LW'(1);

   generate
      if ((DEPTH < 4) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
         $error("Buffer depth must be a power of two of at least four.");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [LW-1:0]    wptr_reg;
   logic [LW-1:0]    rptr_reg;

   assign level_o      = wptr_reg - rptr_reg;
   assign wr_ready_o   = (level_o != FULL_LEVEL);
   assign rd_valid_o   = (level_o != '0);
   assign rd_data_o    = mem[rptr_reg[AW-1:0]];
   assign first_data_o = mem[0];

   // Storage array holds no reset so it maps onto plain memory.
   always_ff @(posedge mclk_i) begin
      if (wr_valid_i && wr_ready_o) begin
         mem[wptr_reg[AW-1:0]] <= wr_data_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_reg <= '0;
      end else if (wr_valid_i && wr_ready_o) begin
         wptr_reg <= wptr_reg + ONE_PTR;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rptr_reg <= '0;
      end else if (rewind_i) begin
         rptr_reg <= rewind_pop_i ? ONE_PTR : '0;
      end else if (rd_valid_o && rd_ready_i) begin
         rptr_reg <= rptr_reg + ONE_PTR;
      end
   end

endmodule

module frc_ctrl #(
   parameter int WIDTH     = `FRC_DATA_WIDTH,
   parameter int DEPTH     = `FRC_FIFO_DEPTH,
   parameter int AE_OFFSET = `FRC_AE_OFFSET,
   parameter int AF_OFFSET = `FRC_AF_OFFSET
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             master_reset_n_i,
   input  wire logic             partial_reset_n_i,
   input  wire logic             mode_select_serial_in_i,
   input  wire logic             async_write_sel_n_i,
   input  wire logic             async_read_sel_n_i,
   input  wire logic             retransmit_latency_sel_i,
   input  wire logic             output_width_sel_i,
   input  wire logic             input_width_sel_i,
   input  wire logic             bus_matching_sel_i,
   input  wire logic             byte_order_sel_i,
   input  wire logic             flag_timing_sel_i,
   input  wire logic             parity_placement_sel_i,
   input  wire logic             write_clk_i,
   input  wire logic             write_enable_n_i,
   input  wire logic [WIDTH-1:0] data_in_i,
   input  wire logic             read_clk_i,
   input  wire logic             read_enable_n_i,
   input  wire logic             replay_request_n_i,
   input  wire logic             output_enable_n_i,
   output logic      [WIDTH-1:0] data_out_o,
   output logic                  data_out_oe_o,
   output logic                  empty_flag_n_o,
   output logic                  full_flag_n_o,
   output logic                  output_ready_n_o,
   output logic                  input_ready_n_o,
   output logic                  almost_empty_flag_n_o,
   output logic                  almost_full_flag_n_o,
   output logic                  half_full_flag_n_o,
   output logic                  fall_through_mode_o,
   output logic                  async_write_o,
   output logic                  async_read_o,
   output logic                  zero_latency_o,
   output logic                  output_width_sel_o,
   output logic                  input_width_sel_o,
   output logic                  bus_matching_sel_o,
   output logic                  byte_order_sel_o,
   output logic                  flag_timing_sel_o,
   output logic                  parity_placement_sel_o
);
   import frc_pkg::*;

   localparam int LW = $clog2(DEPTH) + 1;
   localparam logic [LW-1:0] HALF_LEVEL = LW'(DEPTH / 2);
   localparam logic [LW-1:0] AE_LEVEL   = LW'(AE_OFFSET);
   localparam logic [LW-1:0] AF_LEVEL   = LW'(DEPTH - AF_OFFSET);

   generate
      if ((AE_OFFSET < 1) || (AF_OFFSET < 1) || (AE_OFFSET + AF_OFFSET >= DEPTH)) begin : g_bad
         $error("Flag offsets must be positive and leave room within the depth.");
      end
   endgenerate

   logic             rst_any;
   logic             wclk_prev_reg;
   logic             rclk_prev_reg;
   logic             wr_edge;
   logic             rd_edge;
   logic             fall_through_mode_reg;
   logic             async_write_sel_n_n_reg;
   logic             async_read_sel_n_n_reg;
   logic             rtlat_reg;
   frc_rt_state_t    rt_state_reg;
   frc_rt_state_t    rt_state_next;
   logic             shown_reg;
   logic             shown_next;
   logic             load;
   logic             load_first;
   logic             pop;
   logic             rewind;
   logic             rewind_pop;
   logic             wr_req;
   logic             rd_req;
   logic             rt_start;
   logic             fifo_wr_ready;
   logic             fifo_rd_valid;
   logic [WIDTH-1:0] fifo_rd_data;
   logic [WIDTH-1:0] fifo_first;
   logic [LW-1:0]    level;
   logic             pae_stage_reg;
   logic             paf_stage_reg;

   // Any of the three resets returns pointers, flags and output register at once.
   assign rst_any = rst_i | ~master_reset_n_i | ~partial_reset_n_i;

   assign wr_edge = write_clk_i & ~wclk_prev_reg;
   assign rd_edge = read_clk_i & ~rclk_prev_reg;

   // An asynchronous port takes every strobe edge; the enable is tied low outside.
   assign wr_req = wr_edge & (~async_write_sel_n_n_reg | ~write_enable_n_i);
   assign rd_req = rd_edge & (~async_read_sel_n_n_reg | ~read_enable_n_i);

   assign data_out_oe_o = ~output_enable_n_i;

   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         wclk_prev_reg <= 1'b1;
         rclk_prev_reg <= 1'b1;
      end else begin
         wclk_prev_reg <= write_clk_i;
         rclk_prev_reg <= read_clk_i;
      end
   end

   // Configuration is followed while master reset is low and frozen at release.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fall_through_mode_reg               <= `FRC_MODE_STD;
         async_write_sel_n_n_reg             <= `FRC_ASYNC_SEL_RST;
         async_read_sel_n_n_reg             <= `FRC_ASYNC_SEL_RST;
         rtlat_reg              <= `FRC_RTLAT_NORMAL;
         output_width_sel_o     <= `FRC_CFG_RST;
         input_width_sel_o      <= `FRC_CFG_RST;
         bus_matching_sel_o     <= `FRC_CFG_RST;
         byte_order_sel_o       <= `FRC_CFG_RST;
         flag_timing_sel_o      <= `FRC_CFG_RST;
         parity_placement_sel_o <= `FRC_CFG_RST;
      end else if (!master_reset_n_i) begin
         fall_through_mode_reg               <= mode_select_serial_in_i;
         async_write_sel_n_n_reg             <= async_write_sel_n_i;
         async_read_sel_n_n_reg             <= async_read_sel_n_i;
         rtlat_reg              <= retransmit_latency_sel_i;
         output_width_sel_o     <= output_width_sel_i;
         input_width_sel_o      <= input_width_sel_i;
         bus_matching_sel_o     <= bus_matching_sel_i;
         byte_order_sel_o       <= byte_order_sel_i;
         flag_timing_sel_o      <= flag_timing_sel_i;
         parity_placement_sel_o <= parity_placement_sel_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fall_through_mode_o <= `FRC_MODE_STD;
         async_write_o       <= 1'b0;
         async_read_o        <= 1'b0;
         zero_latency_o      <= 1'b0;
      end else begin
         fall_through_mode_o <= fall_through_mode_reg;
         async_write_o       <= ~async_write_sel_n_n_reg;
         async_read_o        <= ~async_read_sel_n_n_reg;
         zero_latency_o      <= rtlat_reg;
      end
   end

   frc_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH),
      .LW    (LW)
   ) u_fifo (
      .mclk_i       (mclk_i),
      .rst_i        (rst_any),
      .wr_valid_i   (wr_req),
      .wr_ready_o   (fifo_wr_ready),
      .wr_data_i    (data_in_i),
      .rd_valid_o   (fifo_rd_valid),
      .rd_ready_i   (pop),
      .rd_data_o    (fifo_rd_data),
      .rewind_i     (rewind),
      .rewind_pop_i (rewind_pop),
      .first_data_o (fifo_first),
      .level_o      (level)
   );

   assign rt_start = rd_edge & ~replay_request_n_i & (rt_state_reg == RT_IDLE);

   // Read side decision: normal reads, replay setup and fall-through presentation.
   always_comb begin
      rt_state_next = rt_state_reg;
      shown_next    = shown_reg;
      load          = 1'b0;
      load_first    = 1'b0;
      pop           = 1'b0;
      rewind        = 1'b0;
      rewind_pop    = 1'b0;
      case (rt_state_reg)
         RT_IDLE: begin
            if (rt_start) begin
               rewind = 1'b1;
               if (rtlat_reg) begin
                  load_first = 1'b1;
                  rewind_pop = 1'b1;
                  shown_next = 1'b1;
               end else begin
                  rt_state_next = RT_SETUP;
                  shown_next    = 1'b0;
               end
            end else if (!fall_through_mode_reg) begin
               if (rd_req && fifo_rd_valid) begin
                  load = 1'b1;
                  pop  = 1'b1;
               end
            end else if (rd_edge) begin
               if (!shown_reg && fifo_rd_valid) begin
                  load       = 1'b1;
                  pop        = 1'b1;
                  shown_next = 1'b1;
               end else if (shown_reg && !read_enable_n_i) begin
                  load       = fifo_rd_valid;
                  pop        = fifo_rd_valid;
                  shown_next = fifo_rd_valid;
               end
            end
         end
         RT_SETUP: begin
            if (rd_edge) begin
               rt_state_next = RT_IDLE;
               if (fall_through_mode_reg && fifo_rd_valid) begin
                  load       = 1'b1;
                  pop        = 1'b1;
                  shown_next = 1'b1;
               end
            end
         end
         default: begin
            rt_state_next = RT_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         rt_state_reg <= RT_IDLE;
         shown_reg    <= 1'b0;
      end else begin
         rt_state_reg <= rt_state_next;
         shown_reg    <= shown_next;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         data_out_o <= `FRC_DATA_RST;
      end else if (load_first) begin
         data_out_o <= fifo_first;
      end else if (load) begin
         data_out_o <= fifo_rd_data;
      end
   end

   // Standard mode empty flag; the fall-through pair leaves it at its reset level.
   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         empty_flag_n_o <= `FRC_EF_RST;
      end else if (fall_through_mode_reg) begin
         empty_flag_n_o <= `FRC_EF_RST;
      end else if (rt_start && !rtlat_reg) begin
         empty_flag_n_o <= 1'b0;
      end else if (rt_state_reg == RT_SETUP) begin
         if (rd_edge) begin
            empty_flag_n_o <= fifo_rd_valid;
         end
      end else if (!async_read_sel_n_n_reg || rd_edge) begin
         empty_flag_n_o <= (level > LW'(pop)) || load_first;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         full_flag_n_o <= `FRC_FF_RST;
      end else if (fall_through_mode_reg) begin
         full_flag_n_o <= `FRC_FF_RST;
      end else if (!async_write_sel_n_n_reg || wr_edge) begin
         full_flag_n_o <= fifo_wr_ready;
      end
   end

   // Fall-through ready pair; standard mode leaves it at its reset level.
   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         output_ready_n_o <= `FRC_OR_RST;
         input_ready_n_o  <= `FRC_IR_RST;
      end else if (!fall_through_mode_reg) begin
         output_ready_n_o <= `FRC_OR_RST;
         input_ready_n_o  <= `FRC_IR_RST;
      end else begin
         output_ready_n_o <= ~shown_next;
         if (wr_edge) begin
            input_ready_n_o <= ~fifo_wr_ready;
         end
      end
   end

   // Half full follows the level at once, so the replay edge updates it.
   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         half_full_flag_n_o <= `FRC_HF_RST;
      end else begin
         half_full_flag_n_o <= ~(level > HALF_LEVEL);
      end
   end

   // Almost empty passes two read edges, almost full two write edges.
   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         pae_stage_reg         <= `FRC_PAE_RST;
         almost_empty_flag_n_o <= `FRC_PAE_RST;
      end else if (rd_edge) begin
         pae_stage_reg         <= ~(level <= AE_LEVEL);
         almost_empty_flag_n_o <= pae_stage_reg;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_any) begin
      if (rst_any) begin
         paf_stage_reg        <= `FRC_PAF_RST;
         almost_full_flag_n_o <= `FRC_PAF_RST;
      end else if (wr_edge) begin
         paf_stage_reg        <= ~(level >= AF_LEVEL);
         almost_full_flag_n_o <= paf_stage_reg;
      end
   end

endmodule

// >>> tb/frc_ctrl_assertions.sv
// Concurrent checks on the ports of the reset, mode and replay control.
`timescale 1ns/100ps
module frc_ctrl_assertions #(
   parameter int WIDTH = 36
) (
   input wire logic             mclk_i,
   input wire logic             rst_i,
   input wire logic             master_reset_n_i,
   input wire logic             partial_reset_n_i,
   input wire logic             read_clk_i,
   input wire logic             replay_request_n_i,
   input wire logic             output_enable_n_i,
   input wire logic [WIDTH-1:0] data_out_o,
   input wire logic             data_out_oe_o,
   input wire logic             empty_flag_n_o,
   input wire logic             full_flag_n_o,
   input wire logic             output_ready_n_o,
   input wire logic             input_ready_n_o,
   input wire logic             almost_empty_flag_n_o,
   input wire logic             almost_full_flag_n_o,
   input wire logic             half_full_flag_n_o,
   input wire logic             fall_through_mode_o,
   input wire logic             async_read_o,
   input wire logic             zero_latency_o
);
   wire logic run = master_reset_n_i && partial_reset_n_i;
   wire logic lvl = !almost_empty_flag_n_o && almost_full_flag_n_o && half_full_flag_n_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_mrs_lvl; !master_reset_n_i |-> lvl; endproperty
   a_mrs_lvl: assert property (p_mrs_lvl) else $error("level flags off in master reset");
   property p_prs_lvl; !partial_reset_n_i [*2] |-> lvl && data_out_o == '0; endproperty
   a_prs_lvl: assert property (p_prs_lvl) else $error("partial reset state wrong");
   property p_rst_mode;
      !run |-> {empty_flag_n_o, full_flag_n_o, output_ready_n_o, input_ready_n_o} == 4'h6;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("mode flags off in reset");
   property p_mrs_zero; !master_reset_n_i |-> data_out_o == '0; endproperty
   a_mrs_zero: assert property (p_mrs_zero) else $error("output not cleared");
   property p_cfg_hold;
      master_reset_n_i && $past(master_reset_n_i) && $past(master_reset_n_i, 2)
         |-> $stable({fall_through_mode_o, zero_latency_o, async_read_o});
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved outside reset");
   property p_oe; data_out_oe_o == !output_enable_n_i; endproperty
   a_oe: assert property (p_oe) else $error("output enable mismatch");
   property p_replay_std;
      $rose(read_clk_i) && !replay_request_n_i && run && !fall_through_mode_o
         && !zero_latency_o && !async_read_o |=> !empty_flag_n_o;
   endproperty
   a_replay_std: assert property (p_replay_std) else $error("empty not low at setup");
   property p_replay_ft;
      $rose(read_clk_i) && !replay_request_n_i && run && fall_through_mode_o
         && !zero_latency_o |=> output_ready_n_o;
   endproperty
   a_replay_ft: assert property (p_replay_ft) else $error("ready not high at setup");
   c_std: cover property ($rose(read_clk_i) && !replay_request_n_i && !fall_through_mode_o);
   c_ft: cover property ($rose(read_clk_i) && !replay_request_n_i && fall_through_mode_o);
   c_zero: cover property ($rose(read_clk_i) && !replay_request_n_i && zero_latency_o);
endmodule

bind frc_ctrl frc_ctrl_assertions #(.WIDTH(WIDTH)) frc_ctrl_assertions_inst (
   .mclk_i(mclk_i), .rst_i(rst_i), .master_reset_n_i(master_reset_n_i),
   .partial_reset_n_i(partial_reset_n_i), .read_clk_i(read_clk_i),
   .replay_request_n_i(replay_request_n_i), .output_enable_n_i(output_enable_n_i),
   .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o), .empty_flag_n_o(empty_flag_n_o),
   .full_flag_n_o(full_flag_n_o), .output_ready_n_o(output_ready_n_o),
   .input_ready_n_o(input_ready_n_o), .almost_empty_flag_n_o(almost_empty_flag_n_o),
   .almost_full_flag_n_o(almost_full_flag_n_o), .half_full_flag_n_o(half_full_flag_n_o),
   .fall_through_mode_o(fall_through_mode_o), .async_read_o(async_read_o),
   .zero_latency_o(zero_latency_o)
);

// >>> tb/frc_peer.sv
// Writer and reader model that strobes the data path from the far side.
`timescale 1ns/100ps
module frc_peer #(
   parameter int WIDTH = 36
) (
   input  wire logic             mclk_i,
   input  wire logic             async_wr_i,
   input  wire logic             async_rd_i,
   output logic                  write_clk_o,
   output logic                  write_enable_n_o,
   output logic      [WIDTH-1:0] data_in_o,
   output logic                  read_clk_o,
   output logic                  read_enable_n_o,
   output logic                  replay_request_n_o
);
   logic wen_n;
   logic ren_n;
   assign write_enable_n_o = async_wr_i ? 1'b0 : wen_n;
   assign read_enable_n_o  = async_rd_i ? 1'b0 : ren_n;
   initial begin
      write_clk_o = 1'b0;
      read_clk_o = 1'b0;
      wen_n = 1'b1;
      ren_n = 1'b1;
      replay_request_n_o = 1'b1;
      data_in_o = '0;
   end
   task automatic put(input logic [WIDTH-1:0] d);
      @(posedge mclk_i) #2;
      data_in_o = d;
      wen_n = 1'b0;
      write_clk_o = 1'b1;
      @(posedge mclk_i) #2;
      write_clk_o = 1'b0;
      wen_n = 1'b1;
      data_in_o = ~d;
   endtask
   task automatic rclk(input logic r, input logic t);
      @(posedge mclk_i) #2;
      ren_n = r;
      replay_request_n_o = t;
      read_clk_o = 1'b1;
      @(posedge mclk_i) #2;
      read_clk_o = 1'b0;
      ren_n = 1'b1;
      replay_request_n_o = 1'b1;
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the reset, mode and replay control.
`timescale 1ns/100ps
`include "frc_defines.svh"
module tb;
   localparam int W = `FRC_DATA_WIDTH;
   logic         mclk_i;
   logic         rst_i;
   logic         mrs_n;
   logic         prs_n;
   logic         mode;
   logic         asw_n;
   logic         asr_n;
   logic         lat;
   logic         oe_n;
   logic [5:0]   cfg;
   logic [9:0]   cfg_exp;
   logic [31:0]  seed = 32'h0000_0044;
   logic [W-1:0] w[0:16];
   logic [W-1:0] exp_q[$];
   int           n_errors;
   int           n_tests;
   event         got_ev;
   wire logic         wclk, wen_n, rclk, ren_n, rep_n, oe, empty_n, full_n, ready_n, room_n;
   wire logic         ae_n, af_n, half_n, ftm, aw, ar, zl;
   wire logic [5:0]   echo6;
   wire logic [W-1:0] din;
   wire logic [W-1:0] q;
   wire logic [6:0]   flg = {empty_n, full_n, ready_n, room_n, ae_n, af_n, half_n};
   wire logic [9:0]   echo = {ftm, aw, ar, zl, echo6};

   frc_ctrl frc_ctrl_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .master_reset_n_i(mrs_n), .partial_reset_n_i(prs_n),
      .mode_select_serial_in_i(mode), .async_write_sel_n_i(asw_n), .async_read_sel_n_i(asr_n),
      .retransmit_latency_sel_i(lat), .output_width_sel_i(cfg[0]), .input_width_sel_i(cfg[1]),
      .bus_matching_sel_i(cfg[2]), .byte_order_sel_i(cfg[3]), .flag_timing_sel_i(cfg[4]),
      .parity_placement_sel_i(cfg[5]), .write_clk_i(wclk), .write_enable_n_i(wen_n),
      .data_in_i(din), .read_clk_i(rclk), .read_enable_n_i(ren_n), .replay_request_n_i(rep_n),
      .output_enable_n_i(oe_n), .data_out_o(q), .data_out_oe_o(oe), .empty_flag_n_o(empty_n),
      .full_flag_n_o(full_n), .output_ready_n_o(ready_n), .input_ready_n_o(room_n),
      .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .half_full_flag_n_o(half_n),
      .fall_through_mode_o(ftm), .async_write_o(aw), .async_read_o(ar), .zero_latency_o(zl),
      .output_width_sel_o(echo6[0]), .input_width_sel_o(echo6[1]),
      .bus_matching_sel_o(echo6[2]), .byte_order_sel_o(echo6[3]),
      .flag_timing_sel_o(echo6[4]), .parity_placement_sel_o(echo6[5]));
   frc_peer #(.WIDTH(W)) frc_peer_inst (
      .mclk_i(mclk_i), .async_wr_i(aw), .async_rd_i(ar), .write_clk_o(wclk),
      .write_enable_n_o(wen_n), .data_in_o(din), .read_clk_o(rclk), .read_enable_n_o(ren_n),
      .replay_request_n_o(rep_n));

   function automatic logic [W-1:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return {seed[3:0], seed ^ 32'h5a5a_a5a5};
   endfunction
   task automatic check(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask
   task automatic mreset(input logic m, input logic a, input logic b, input logic l);
      logic [W-1:0] r;
      r = rnd();
      @(posedge mclk_i) #2;
      {mode, asw_n, asr_n, lat, cfg} = {m, a, b, l, r[5:0]};
      cfg_exp = {m, !a, !b, l, r[5:0]};
      mrs_n = 1'b0;
      wt(3);
      check("flags", W'(7'h33), W'(flg));
      check("data_out_o", '0, q);
      mrs_n = 1'b1;
      wt(3);
      check("config", W'(cfg_exp), W'(echo));
   endtask
   task automatic fill(input int n);
      for (int i = 0; i < n; i++) begin
         w[i] = rnd();
         frc_peer_inst.put(w[i]);
      end
      wt(3);
   endtask
   task automatic pull(input logic r, input logic t, input logic [W-1:0] e);
      exp_q.push_back(e);
      frc_peer_inst.rclk(r, t);
      wt(2);
      -> got_ev;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(got_ev) begin
      check("data_out_o", exp_q.pop_front(), q);
   end
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_errors++;
      finish_test();
   end
   initial begin
      {rst_i, mrs_n, prs_n, mode, asw_n, asr_n, lat, oe_n} = 8'hed;
      cfg = 6'h00;
      repeat (12) @(posedge mclk_i);
      #2 rst_i = 1'b0;
      mreset(1'b0, 1'b1, 1'b1, 1'b0);
      oe_n = 1'b0;
      #1 check("oe", W'(1'b1), W'(oe));
      @(posedge mclk_i) #2 oe_n = 1'b1;
      #1 check("oe", '0, W'(oe));
      fill(4);
      pull(1'b0, 1'b1, w[0]);
      pull(1'b0, 1'b1, w[1]);
      pull(1'b1, 1'b1, w[1]);
      frc_peer_inst.rclk(1'b1, 1'b0);
      wt(1);
      check("empty_flag_n_o", '0, W'(empty_n));
      frc_peer_inst.rclk(1'b1, 1'b1);
      wt(2);
      check("empty_flag_n_o", W'(1'b1), W'(empty_n));
      pull(1'b0, 1'b1, w[0]);
      @(posedge mclk_i) #2 prs_n = 1'b0;
      wt(2);
      check("flags", W'(7'h33), W'(flg));
      check("data_out_o", '0, q);
      prs_n = 1'b1;
      wt(2);
      check("config", W'(cfg_exp), W'(echo));
      mreset(1'b1, 1'b1, 1'b1, 1'b0);
      fill(3);
      pull(1'b1, 1'b1, w[0]);
      check("output_ready_n_o", '0, W'(ready_n));
      pull(1'b0, 1'b1, w[1]);
      frc_peer_inst.rclk(1'b1, 1'b0);
      wt(1);
      check("output_ready_n_o", W'(1'b1), W'(ready_n));
      pull(1'b1, 1'b1, w[0]);
      check("output_ready_n_o", '0, W'(ready_n));
      mreset(1'b0, 1'b1, 1'b1, 1'b1);
      fill(4);
      pull(1'b0, 1'b1, w[0]);
      pull(1'b0, 1'b1, w[1]);
      pull(1'b0, 1'b0, w[0]);
      pull(1'b0, 1'b1, w[1]);
      mreset(1'b0, 1'b0, 1'b0, 1'b0);
      fill(17);
      check("flags", W'(7'h50), W'(flg));
      pull(1'b0, 1'b1, w[0]);
      check("full_flag_n_o", W'(1'b1), W'(full_n));
      for (int i = 1; i < 16; i++) pull(1'b0, 1'b1, w[i]);
      wt(2);
      check("flags", W'(7'h31), W'(flg));
      fill(1);
      check("empty_flag_n_o", W'(1'b1), W'(empty_n));
      pull(1'b0, 1'b1, w[0]);
      finish_test();
   end
endmodule
